// ---- rtl/ccss_pkg.sv ----
// Constants and types shared by the character set select block
package ccss_pkg;
   localparam int           CCSS_SET_W       = 7;
   localparam logic [6:0]   CCSS_SET_DEFAULT = 7'h00;
   localparam logic [6:0]   CCSS_SET_DOWNLD  = 7'h7f;
   localparam int           CCSS_GRP0_LO     = 0;
   localparam int           CCSS_GRP0_HI     = 19;
   localparam int           CCSS_GRP1_LO     = 30;
   localparam int           CCSS_GRP1_HI     = 49;
   localparam logic [7:0]   CCSS_CODE_SO     = 8'h0e;
   localparam logic [7:0]   CCSS_CODE_SI     = 8'h0f;
   localparam logic [7:0]   CCSS_CTL_LO_MAX  = 8'h1f;
   localparam logic [7:0]   CCSS_CTL_HI_MIN  = 8'h80;
   localparam logic [7:0]   CCSS_CTL_HI_MAX  = 8'h9f;
   localparam logic [7:0]   CCSS_MSB_MASK    = 8'h7f;
   localparam logic [3:0]   CCSS_ERR_NONE    = 4'h0;
   localparam logic [3:0]   CCSS_ERR_PARAMS  = 4'h2;
   localparam logic [3:0]   CCSS_ERR_RANGE   = 4'h5;
   localparam logic [0:0]   CCSS_SLOT_STD    = 1'h0;
   localparam logic [0:0]   CCSS_SLOT_ALT    = 1'h1;
   localparam int           CCSS_BUF_DEPTH   = 2;
   typedef enum logic [2:0] {
      CCSS_OP_DESIG_STD,
      CCSS_OP_DESIG_ALT,
      CCSS_OP_SEL_STD,
      CCSS_OP_SEL_ALT,
      CCSS_OP_SLOT_DESIG,
      CCSS_OP_SLOT_INV,
      CCSS_OP_MODE,
      CCSS_OP_DEFAULTS
   } ccss_op_t;
   typedef enum logic [1:0] {
      CCSS_MODE_C7,
      CCSS_MODE_P8,
      CCSS_MODE_I7,
      CCSS_MODE_I8
   } ccss_mode_t;
endpackage : ccss_pkg

// ---- rtl/ccss_buf.sv ----
// Two-entry valid/ready buffer for the label output path
`timescale 1ns/100ps
module ccss_buf #(
   parameter int W = 15
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   logic [W-1:0] mem [0:1];
   logic [W-1:0] next_mem [0:1];
   logic [1:0]   count;
   logic [1:0]   next_count;
   logic         push;
   logic         pop;

   always_comb begin
      push          = in_valid_i && in_ready_o;
      pop           = out_valid_o && out_ready_i;
      next_mem[0]   = mem[0];
      next_mem[1]   = mem[1];
      next_count    = count;
      // Entry 0 is always the head, so the output is a flop
      if (pop) begin
         next_mem[0] = mem[1];
      end
      if (push) begin
         if (count == 2'h0 || (count == 2'h1 && pop)) begin
            next_mem[0] = in_data_i;
         end else begin
            next_mem[1] = in_data_i;
         end
      end
      next_count = 2'(count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem[0] <= '0;
         mem[1] <= '0;
         count  <= 2'h0;
      end else begin
         mem[0] <= next_mem[0];
         mem[1] <= next_mem[1];
         count  <= next_count;
      end
   end

   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = mem[0];
endmodule : ccss_buf

// ---- rtl/ccss_top.sv ----
// Character set designation, selection and label byte filtering
`timescale 1ns/100ps
module ccss_top
   import ccss_pkg::*;
(
   // Clock and reset
   input  wire logic                  CORE_CLK_I,
   input  wire logic                  RST_B_I,
   // Instruction from the parser
   input  wire logic                  CMD_VALID_I,
   input  wire ccss_pkg::ccss_op_t    CMD_OP_I,
   input  wire logic [7:0]            CMD_NPARAM_I,
   input  wire logic signed [15:0]    CMD_PARAM0_I,
   input  wire logic signed [15:0]    CMD_PARAM1_I,
   // Label bytes in
   input  wire logic                  LBL_VALID_I,
   output logic                       LBL_READY_O,
   input  wire logic [7:0]            LBL_BYTE_I,
   // Characters to draw out
   output logic                       CHR_VALID_O,
   input  wire logic                  CHR_READY_I,
   output logic [7:0]                 CHR_CODE_O,
   output logic [6:0]                 CHR_SET_O,
   // State and errors
   output logic [6:0]                 STD_SET_O,
   output logic [6:0]                 ALT_SET_O,
   output logic                       ALT_SELECTED_O,
   output ccss_pkg::ccss_mode_t       MODE_O,
   output logic                       ERR_VALID_O,
   output logic [3:0]                 ERR_CODE_O
);
   import ccss_pkg::*;

   logic [6:0] std_set, next_std_set;
   logic [6:0] alt_set, next_alt_set;
   logic       alt_sel, next_alt_sel;
   ccss_mode_t mode, next_mode;
   logic       err_v, next_err_v;
   logic [3:0] err_c, next_err_c;
   logic       lbl_take;
   logic [7:0] lbl_b;
   logic       buf_ready;
   logic       buf_push;
   logic [6:0] active_set;
   logic [14:0] buf_out;

   // Range check and encoding of a set number, -1 maps to all ones
   function automatic logic set_ok(input logic signed [15:0] v);
      set_ok = (v == -16'sd1) || (v >= 16'(CCSS_GRP0_LO) && v <= 16'(CCSS_GRP0_HI)) ||
               (v >= 16'(CCSS_GRP1_LO) && v <= 16'(CCSS_GRP1_HI));
   endfunction : set_ok

   function automatic logic [6:0] set_enc(input logic signed [15:0] v);
      set_enc = (v == -16'sd1) ? CCSS_SET_DOWNLD : v[6:0];
   endfunction : set_enc

   // Commands take priority over a shift code in the same cycle
   assign lbl_take = LBL_VALID_I && LBL_READY_O;
   assign lbl_b    = (mode == CCSS_MODE_C7) ? (LBL_BYTE_I & CCSS_MSB_MASK) : LBL_BYTE_I;

   always_comb begin
      next_std_set = std_set;
      next_alt_set = alt_set;
      next_alt_sel = alt_sel;
      next_mode    = mode;
      next_err_v   = 1'b0;
      next_err_c   = err_c;
      if (CMD_VALID_I) begin
         case (CMD_OP_I)
            CCSS_OP_DESIG_STD, CCSS_OP_DESIG_ALT: begin
               if (CMD_NPARAM_I == 8'h00) begin
                  if (CMD_OP_I == CCSS_OP_DESIG_STD) begin
                     next_std_set = CCSS_SET_DEFAULT;
                  end else begin
                     next_alt_set = CCSS_SET_DEFAULT;
                  end
               end else if (!set_ok(CMD_PARAM0_I)) begin
                  next_err_v = 1'b1;
                  next_err_c = CCSS_ERR_RANGE;
               end else begin
                  // Selection is not touched, so the new set shows only when its side is active
                  if (CMD_OP_I == CCSS_OP_DESIG_STD) begin
                     next_std_set = set_enc(CMD_PARAM0_I);
                  end else begin
                     next_alt_set = set_enc(CMD_PARAM0_I);
                  end
                  if (CMD_NPARAM_I > 8'h01) begin
                     next_err_v = 1'b1;
                     next_err_c = CCSS_ERR_PARAMS;
                  end
               end
            end
            CCSS_OP_SEL_STD, CCSS_OP_SEL_ALT: begin
               next_alt_sel = (CMD_OP_I == CCSS_OP_SEL_ALT);
               if (CMD_NPARAM_I != 8'h00) begin
                  next_err_v = 1'b1;
                  next_err_c = CCSS_ERR_PARAMS;
               end
            end
            CCSS_OP_SLOT_DESIG: begin
               // Only slots 0 and 1 are held here; others belong to the extended logic
               if (CMD_NPARAM_I >= 8'h02 && set_ok(CMD_PARAM1_I)) begin
                  if (CMD_PARAM0_I == 16'sd0) begin
                     next_std_set = set_enc(CMD_PARAM1_I);
                  end else if (CMD_PARAM0_I == 16'sd1) begin
                     next_alt_set = set_enc(CMD_PARAM1_I);
                  end
               end
            end
            CCSS_OP_SLOT_INV: begin
               if (CMD_NPARAM_I >= 8'h01 && CMD_PARAM0_I == 16'sd0) begin
                  next_alt_sel = CCSS_SLOT_STD;
               end else if (CMD_NPARAM_I >= 8'h01 && CMD_PARAM0_I == 16'sd1) begin
                  next_alt_sel = CCSS_SLOT_ALT;
               end
            end
            CCSS_OP_MODE: begin
               if (CMD_NPARAM_I >= 8'h01 && CMD_PARAM0_I >= 16'sd0 && CMD_PARAM0_I <= 16'sd3) begin
                  next_mode = ccss_mode_t'(CMD_PARAM0_I[1:0]);
               end
            end
            CCSS_OP_DEFAULTS: begin
               next_std_set = CCSS_SET_DEFAULT;
               next_alt_set = CCSS_SET_DEFAULT;
               next_alt_sel = 1'b0;
               next_mode    = CCSS_MODE_C7;
            end
            default: begin
               next_err_v = 1'b0;
            end
         endcase
      end else if (lbl_take && lbl_b == CCSS_CODE_SI) begin
         next_alt_sel = 1'b0;
      end else if (lbl_take && lbl_b == CCSS_CODE_SO) begin
         next_alt_sel = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         std_set <= CCSS_SET_DEFAULT;
         alt_set <= CCSS_SET_DEFAULT;
         alt_sel <= 1'b0;
         mode    <= CCSS_MODE_C7;
         err_v   <= 1'b0;
         err_c   <= CCSS_ERR_NONE;
      end else begin
         std_set <= next_std_set;
         alt_set <= next_alt_set;
         alt_sel <= next_alt_sel;
         mode    <= next_mode;
         err_v   <= next_err_v;
         err_c   <= next_err_c;
      end
   end

   // Label bytes wait while a command is applied, so the set tagged is always current
   assign LBL_READY_O = buf_ready && !CMD_VALID_I;
   assign active_set  = alt_sel ? alt_set : std_set;
   // Shift codes and other control codes never reach the drawing side
   assign buf_push    = lbl_take && (lbl_b > CCSS_CTL_LO_MAX) &&
                        !(lbl_b >= CCSS_CTL_HI_MIN && lbl_b <= CCSS_CTL_HI_MAX);

   ccss_buf #(
      .W (15)
   ) u_buf (
      .clk_i       (CORE_CLK_I),
      .rst_b_i     (RST_B_I),
      .in_valid_i  (buf_push),
      .in_ready_o  (buf_ready),
      .in_data_i   ({active_set, lbl_b}),
      .out_valid_o (CHR_VALID_O),
      .out_ready_i (CHR_READY_I),
      .out_data_o  (buf_out)
   );

   assign CHR_CODE_O     = buf_out[7:0];
   assign CHR_SET_O      = buf_out[14:8];
   assign STD_SET_O      = std_set;
   assign ALT_SET_O      = alt_set;
   assign ALT_SELECTED_O = alt_sel;
   assign MODE_O         = mode;
   assign ERR_VALID_O    = err_v;
   assign ERR_CODE_O     = err_c;

   a_range_ignored: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (CMD_VALID_I && CMD_OP_I == CCSS_OP_DESIG_STD && CMD_NPARAM_I != 8'h00 && !set_ok(CMD_PARAM0_I))
      |=> (ERR_VALID_O && ERR_CODE_O == 4'h5 && $stable(STD_SET_O)))
      else $error("Out of range designation not ignored");
   a_extra_params: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (CMD_VALID_I && CMD_OP_I == CCSS_OP_DESIG_ALT && CMD_NPARAM_I > 8'h01 && set_ok(CMD_PARAM0_I))
      |=> (ERR_CODE_O == 4'h2 && ALT_SET_O == set_enc($past(CMD_PARAM0_I))))
      else $error("Extra parameter handling wrong");
   a_empty_desig: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (CMD_VALID_I && CMD_OP_I == CCSS_OP_DESIG_STD && CMD_NPARAM_I == 8'h00)
      |=> (STD_SET_O == 7'h00 && !ERR_VALID_O))
      else $error("Empty designation wrong");
   a_select_err: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (CMD_VALID_I && CMD_OP_I == CCSS_OP_SEL_ALT && CMD_NPARAM_I != 8'h00)
      |=> (ALT_SELECTED_O && ERR_VALID_O && ERR_CODE_O == 4'h2))
      else $error("Select with parameters wrong");
   a_shift_codes: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (!CMD_VALID_I && lbl_take && lbl_b == 8'h0e) |=> ALT_SELECTED_O)
      else $error("Shift out ignored");
   a_ctl_dropped: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (lbl_take && lbl_b <= 8'h1f && !CHR_VALID_O) |=> !CHR_VALID_O)
      else $error("Control code drawn");
   // Checked through an empty buffer, so a byte queued under another mode cannot trip it
   a_msb_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (buf_push && !CHR_VALID_O && MODE_O == CCSS_MODE_C7) |=> (CHR_VALID_O && !CHR_CODE_O[7]))
      else $error("High bit passed in compatibility mode");
   a_sel_persist: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (!CMD_VALID_I && !(lbl_take && (lbl_b == 8'h0e || lbl_b == 8'h0f))) |=> $stable(ALT_SELECTED_O))
      else $error("Selection changed without cause");
endmodule : ccss_top

// ---- testbench/ccss_drain.sv ----
// Character drain model that can stall or accept slowly
`timescale 1ns/100ps
module ccss_drain (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Pacing from the bench
   input  wire logic       stall_i,
   input  wire logic       slow_i,
   // Character stream
   input  wire logic       valid_i,
   output logic            ready_o,
   input  wire logic [7:0] code_i,
   input  wire logic [6:0] set_i
);
   logic [14:0] got[$];
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ready_o <= 1'b0;
      end else begin
         if (valid_i && ready_o) begin
            got.push_back({set_i, code_i});
         end
         // Slow pacing drops ready every other cycle
         ready_o <= !stall_i && !(slow_i && ready_o);
      end
   end
endmodule : ccss_drain

// ---- testbench/ccss_top_tb_top.sv ----
// Self-checking bench for the character set select block
`timescale 1ns/100ps
module ccss_top_tb_top;
   import ccss_pkg::*;
   logic               CORE_CLK_I = 0, RST_B_I = 0, CMD_VALID_I = 0;
   ccss_op_t           CMD_OP_I = CCSS_OP_DESIG_STD;
   logic [7:0]         CMD_NPARAM_I = 0, LBL_BYTE_I = 0, CHR_CODE_O;
   logic signed [15:0] CMD_PARAM0_I = 0, CMD_PARAM1_I = 0;
   logic               LBL_VALID_I = 0, LBL_READY_O, CHR_VALID_O, CHR_READY_I;
   logic [6:0]         CHR_SET_O, STD_SET_O, ALT_SET_O;
   logic               ALT_SELECTED_O, ERR_VALID_O, stall = 0, slow = 0;
   ccss_mode_t         MODE_O;
   logic [3:0]         ERR_CODE_O;
   int                 fails = 0, checks_done = 0;
   ccss_top uut (.CORE_CLK_I, .RST_B_I, .CMD_VALID_I, .CMD_OP_I, .CMD_NPARAM_I, .CMD_PARAM0_I,
      .CMD_PARAM1_I, .LBL_VALID_I, .LBL_READY_O, .LBL_BYTE_I, .CHR_VALID_O, .CHR_READY_I,
      .CHR_CODE_O, .CHR_SET_O, .STD_SET_O, .ALT_SET_O, .ALT_SELECTED_O, .MODE_O, .ERR_VALID_O,
      .ERR_CODE_O);
   ccss_drain drain (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .stall_i(stall), .slow_i(slow),
      .valid_i(CHR_VALID_O), .ready_o(CHR_READY_I), .code_i(CHR_CODE_O), .set_i(CHR_SET_O));
   initial begin
      forever #50 CORE_CLK_I = ~CORE_CLK_I;
   end
   task report_and_stop;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task cmd(input ccss_op_t op, input int n, input int p0, input int p1, input logic [3:0] e);
      @(posedge CORE_CLK_I);
      CMD_VALID_I <= 1'b1;
      CMD_OP_I <= op;
      CMD_NPARAM_I <= 8'(n);
      CMD_PARAM0_I <= 16'(p0);
      CMD_PARAM1_I <= 16'(p1);
      @(posedge CORE_CLK_I);
      CMD_VALID_I <= 1'b0;
      #1;
      chk("err_valid", 16'(e != 0), 16'(ERR_VALID_O));
      if (e != 0) chk("err_code", 16'(e), 16'(ERR_CODE_O));
   endtask : cmd
   task lbl(input logic [7:0] b);
      int i;
      @(posedge CORE_CLK_I);
      LBL_VALID_I <= 1'b1;
      LBL_BYTE_I <= b;
      i = 0;
      do begin
         @(posedge CORE_CLK_I);
         i++;
      end while (LBL_READY_O !== 1'b1 && i < 50);
      LBL_VALID_I <= 1'b0;
      if (i >= 50) chk("lbl_ready", 16'h1, 16'h0);
   endtask : lbl
   task exp_chr(input logic [7:0] cd, input logic [6:0] st);
      int         i;
      logic [14:0] g;
      i = 0;
      while (drain.got.size() == 0 && i < 50) begin
         @(negedge CORE_CLK_I);
         i++;
      end
      if (drain.got.size() == 0) chk("chr_count", 16'h1, 16'h0);
      else begin
         g = drain.got.pop_front();
         chk("chr_code", 16'(cd), 16'(g[7:0]));
         chk("chr_set", 16'(st), 16'(g[14:8]));
      end
   endtask : exp_chr
   task exp_none;
      repeat (6) @(negedge CORE_CLK_I);
      chk("chr_extra", 16'h0, 16'(drain.got.size()));
   endtask : exp_none
   task t_reset;
      chk("std", 16'h0, 16'(STD_SET_O));
      chk("alt", 16'h0, 16'(ALT_SET_O));
      chk("alt_sel", 16'h0, 16'(ALT_SELECTED_O));
      chk("mode", 16'(CCSS_MODE_C7), 16'(MODE_O));
   endtask : t_reset
   task t_desig;
      static int pv[8] = '{-1, 19, 30, 49, 20, 29, 50, -2};
      for (int j = 0; j < 2; j++) begin
         for (int k = 0; k < 8; k++) begin
            cmd(j ? CCSS_OP_DESIG_ALT : CCSS_OP_DESIG_STD, 1, pv[k], 0, k < 4 ? 4'h0 : 4'h5);
            chk("set", 16'(k < 4 ? pv[k][6:0] : 7'h31), 16'(j ? ALT_SET_O : STD_SET_O));
         end
      end
      cmd(CCSS_OP_DESIG_STD, 0, 9, 0, 4'h0);
      chk("std", 16'h0, 16'(STD_SET_O));
      cmd(CCSS_OP_DESIG_ALT, 2, 12, 3, 4'h2);
      chk("alt", 16'hc, 16'(ALT_SET_O));
      cmd(CCSS_OP_DESIG_ALT, 0, 0, 0, 4'h0);
      chk("alt", 16'h0, 16'(ALT_SET_O));
   endtask : t_desig
   task t_select;
      cmd(CCSS_OP_SEL_ALT, 1, 5, 0, 4'h2);
      chk("alt_sel", 16'h1, 16'(ALT_SELECTED_O));
      cmd(CCSS_OP_SEL_STD, 0, 0, 0, 4'h0);
      chk("alt_sel", 16'h0, 16'(ALT_SELECTED_O));
      cmd(CCSS_OP_SEL_STD, 3, 1, 1, 4'h2);
      chk("alt_sel", 16'h0, 16'(ALT_SELECTED_O));
   endtask : t_select
   task t_label;
      static logic [7:0] bs[8] = '{8'h33, 8'h0e, 8'h78, 8'h0f, 8'h2d, 8'h01, 8'h9f, 8'hc1};
      slow <= 1'b1;
      cmd(CCSS_OP_DESIG_STD, 1, 30, 0, 4'h0);
      cmd(CCSS_OP_DESIG_ALT, 1, 7, 0, 4'h0);
      foreach (bs[k]) lbl(bs[k]);
      exp_chr(8'h33, 7'd30);
      exp_chr(8'h78, 7'd7);
      exp_chr(8'h2d, 7'd30);
      exp_chr(8'h41, 7'd30);
      exp_none();
      slow <= 1'b0;
   endtask : t_label
   task t_follow;
      cmd(CCSS_OP_DESIG_ALT, 1, 5, 0, 4'h0);
      lbl(8'h61);
      exp_chr(8'h61, 7'd30);
      lbl(8'h0e);
      lbl(8'h62);
      exp_chr(8'h62, 7'd5);
      cmd(CCSS_OP_DESIG_ALT, 1, 9, 0, 4'h0);
      lbl(8'h63);
      exp_chr(8'h63, 7'd9);
      cmd(CCSS_OP_DESIG_STD, 1, 1, 0, 4'h0);
      lbl(8'h64);
      exp_chr(8'h64, 7'd9);
      cmd(CCSS_OP_SEL_STD, 2, 0, 0, 4'h2);
      lbl(8'h65);
      exp_chr(8'h65, 7'd1);
   endtask : t_follow
   task t_stall;
      stall <= 1'b1;
      repeat (2) @(posedge CORE_CLK_I);
      lbl(8'h41);
      lbl(8'h42);
      @(posedge CORE_CLK_I);
      #1;
      chk("lbl_ready_full", 16'h0, 16'(LBL_READY_O));
      chk("chr_valid", 16'h1, 16'(CHR_VALID_O));
      stall <= 1'b0;
      exp_chr(8'h41, 7'd1);
      exp_chr(8'h42, 7'd1);
      exp_none();
   endtask : t_stall
   task t_slots;
      // Mode select, slot designations, invocation, then labels
      // Ends in the 8-bit ISO mode so the upper control range is exercised below
      for (int k = 0; k < 4; k++) begin
         cmd(CCSS_OP_MODE, 1, k, 0, 4'h0);
         chk("mode", 16'(k), 16'(MODE_O));
      end
      cmd(CCSS_OP_MODE, 1, 4, 0, 4'h0);
      chk("mode", 16'(CCSS_MODE_I8), 16'(MODE_O));
      cmd(CCSS_OP_SLOT_DESIG, 2, 0, 40, 4'h0);
      chk("std", 16'd40, 16'(STD_SET_O));
      cmd(CCSS_OP_SLOT_DESIG, 2, 1, 41, 4'h0);
      chk("alt", 16'd41, 16'(ALT_SET_O));
      cmd(CCSS_OP_SLOT_INV, 1, 1, 0, 4'h0);
      chk("alt_sel", 16'h1, 16'(ALT_SELECTED_O));
      lbl(8'h85);
      lbl(8'hc1);
      exp_chr(8'hc1, 7'd41);
      exp_none();
      cmd(CCSS_OP_DEFAULTS, 0, 0, 0, 4'h0);
      t_reset();
   endtask : t_slots
   initial begin
      repeat (5) @(posedge CORE_CLK_I);
      RST_B_I <= 1'b1;
      @(posedge CORE_CLK_I);
      #1;
      t_reset();
      t_desig();
      t_select();
      t_label();
      t_follow();
      t_stall();
      t_slots();
      report_and_stop();
   end
   initial begin
      #2000000;
      fails++;
      report_and_stop();
   end
endmodule : ccss_top_tb_top
